// ---- rtl/dpss_setup.sv ----
// Purpose: Start-up registers of a fieldbus slave controller behind an APB slave
// Assumes: Link events arrive as one-cycle pulses synchronous to clock
// Notes:   APB answers with pready one cycle into the access phase
//
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "dpss_defs.svh"

module dpss_setup #(
   parameter int unsigned TICK_CYCLES   = `DPSS_TICK_MS * `DPSS_CLK_MHZ * 1000,
   parameter int unsigned IO_MEM_BYTES  = `DPSS_IO_MEM_BYTES
) (
   // Clock and reset
   input  wire logic              clock,
   input  wire logic              rst,
   // APB slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic                   pready_q,
   output logic [31:0]            prdata_q,
   output logic                   pslverr_q,
   // Fieldbus engine
   input  wire dpss_pkg::dpss_link_t link_in,
   output logic                   online_q,
   output logic                   baud_search_q,
   // Host indication
   output logic                   irq_q
);

   dpss_pkg::dpss_state_t state_q, state_d;
   logic [7:0]  cfg_len_q,   cfg_len_d;
   logic [7:0]  in_len_q,    in_len_d;
   logic [7:0]  out_len_q,   out_len_d;
   logic        io_ok_q,     io_ok_d;
   logic [7:0]  baud_root_q, baud_root_d;
   logic [15:0] ind_stat_q,  ind_stat_d;
   logic [15:0] ind_en_q,    ind_en_d;
   logic [1:0]  diag_free_q, diag_free_d;
   logic [8:0]  acc_in_q,    acc_in_d;
   logic [8:0]  acc_out_q,   acc_out_d;
   logic [7:0]  id_cnt_q,    id_cnt_d;
   logic        irq_d;
   logic        online_d;
   logic        search_d;
   logic        pready_d;
   logic [31:0] prdata_d;
   logic        pslverr_d;
   logic        wr_done;
   logic        rd_done;
   logic        mon_expire;
   logic [7:0]  mon_root;
   logic        calc_ok;
   logic [15:0] set_ev;
   logic [8:0]  sum_in, sum_out;

   // Byte count of one identifier in one direction
   function automatic logic [8:0] id_bytes(input logic [7:0] id, input logic dir_bit);
      logic [8:0] n;
      n = 9'(id[`DPSS_ID_LEN_MSB:0]) + 9'h001;
      if (id[`DPSS_ID_WORD]) begin
         n = 9'(n << 1);
      end
      id_bytes = dir_bit ? n : 9'h000;
   endfunction : id_bytes

   // Address match at word alignment
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a[7:2] == ofs[7:2]);
   endfunction : hit

   // APB completion strobes
   assign wr_done = psel && penable && pready_q && pwrite;
   assign rd_done = psel && penable && pready_q && !pwrite;

   // Running byte sums, bit 8 is the carry out of the 8-bit length
   assign sum_in  = 9'(acc_in_q[7:0]) + id_bytes(pwdata[7:0], pwdata[`DPSS_ID_IN]);
   assign sum_out = 9'(acc_out_q[7:0]) + id_bytes(pwdata[7:0], pwdata[`DPSS_ID_OUT]);

   // Master watchdog value overrides local root
   assign mon_root = link_in.wd_en ? link_in.wd_value : baud_root_q;

   // Calculated lengths valid only for a consistent configuration
   assign calc_ok = (cfg_len_q != 8'h00) && (id_cnt_q == cfg_len_q)
                    && !acc_in_q[8] && !acc_out_q[8];

   // Baud monitoring timer
   dpss_baud_mon #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_mon (
      .clock    (clock),
      .rst      (rst),
      .run      (state_q == dpss_pkg::ST_ONLINE),
      .restart  (link_in.msg_valid),
      .root     (mon_root),
      .expire_q (mon_expire)
   );

   // Link state machine
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         dpss_pkg::ST_OFFLINE: begin
            if (wr_done && hit(paddr, `DPSS_OFS_CTRL) && pwdata[`DPSS_CTRL_GO]) begin
               state_d = dpss_pkg::ST_BAUD_SEARCH;
            end
         end
         dpss_pkg::ST_BAUD_SEARCH: begin
            if (link_in.baud_found) begin
               state_d = dpss_pkg::ST_ONLINE;
            end
         end
         dpss_pkg::ST_ONLINE: begin
            if (mon_expire) begin
               state_d = dpss_pkg::ST_BAUD_SEARCH;
            end
         end
         default: state_d = dpss_pkg::ST_OFFLINE;
      endcase
      online_d = (state_d != dpss_pkg::ST_OFFLINE);
      search_d = (state_d == dpss_pkg::ST_BAUD_SEARCH);
   end

   // Indication status, enable and interrupt
   always_comb begin
      set_ev = link_in.events;
      if (state_q == dpss_pkg::ST_BAUD_SEARCH && link_in.baud_found) begin
         set_ev[`DPSS_IND_BAUD_DET] = 1'b1;
      end
      ind_stat_d = ind_stat_q;
      ind_en_d   = ind_en_q;
      if (wr_done && hit(paddr, `DPSS_OFS_IND_STAT)) begin
         ind_stat_d = ind_stat_d & ~pwdata[15:0];
      end
      if (wr_done && hit(paddr, `DPSS_OFS_IND_EN)) begin
         ind_en_d = pwdata[15:0];
      end
      ind_stat_d = ind_stat_d | set_ev;
      irq_d      = |(ind_stat_d & ind_en_d);
   end

   // Configuration, lengths and buffer bookkeeping
   always_comb begin
      cfg_len_d   = cfg_len_q;
      in_len_d    = in_len_q;
      out_len_d   = out_len_q;
      io_ok_d     = io_ok_q;
      baud_root_d = baud_root_q;
      diag_free_d = diag_free_q;
      acc_in_d    = acc_in_q;
      acc_out_d   = acc_out_q;
      id_cnt_d    = id_cnt_q;
      if (wr_done && hit(paddr, `DPSS_OFS_CFG_LEN)) begin
         cfg_len_d = pwdata[7:0];
      end
      if (wr_done && hit(paddr, `DPSS_OFS_IO_LEN)) begin
         in_len_d  = pwdata[7:0];
         out_len_d = pwdata[15:8];
         io_ok_d   = (10'(pwdata[7:0]) + 10'(pwdata[15:8])) <= 10'(IO_MEM_BYTES);
      end
      if (wr_done && hit(paddr, `DPSS_OFS_BAUD_ROOT)) begin
         baud_root_d = pwdata[7:0];
      end
      if (wr_done && hit(paddr, `DPSS_OFS_CTRL) && pwdata[`DPSS_CTRL_ID_CLR]) begin
         acc_in_d  = 9'h000;
         acc_out_d = 9'h000;
         id_cnt_d  = 8'h00;
      end else if (wr_done && hit(paddr, `DPSS_OFS_CFG_ID)) begin
         acc_in_d  = {acc_in_q[8] | sum_in[8], sum_in[7:0]};
         acc_out_d = {acc_out_q[8] | sum_out[8], sum_out[7:0]};
         id_cnt_d  = id_cnt_q + 8'h01;
      end
      if (link_in.diag_returned) begin
         diag_free_d = diag_free_q[0] ? (diag_free_q | 2'b10) : (diag_free_q | 2'b01);
      end
      if (rd_done && hit(paddr, `DPSS_OFS_DIAG_PTR) && prdata_q != 32'h0) begin
         diag_free_d[prdata_q[15:0] == `DPSS_DIAG1_PTR] = 1'b0;
      end
   end

   // APB answer one cycle into the access phase
   always_comb begin
      pready_d  = psel && penable && !pready_q;
      prdata_d  = 32'h0;
      pslverr_d = 1'b0;
      if (psel && penable && !pready_q) begin
         unique case (paddr[7:2])
            `DPSS_OFS_CTRL      >> 2: prdata_d = 32'h0;
            `DPSS_OFS_CFG_PTR   >> 2: prdata_d = 32'(`DPSS_CFG_BUF_PTR);
            `DPSS_OFS_CFG_LEN   >> 2: prdata_d = 32'(cfg_len_q);
            `DPSS_OFS_IO_LEN    >> 2: prdata_d = {15'h0, io_ok_q, out_len_q, in_len_q};
            `DPSS_OFS_DIN_PTR   >> 2: prdata_d = 32'(`DPSS_DIN_BUF_PTR);
            `DPSS_OFS_DIAG_PTR  >> 2: begin
               if (diag_free_q[0]) begin
                  prdata_d = 32'(`DPSS_DIAG0_PTR);
               end else if (diag_free_q[1]) begin
                  prdata_d = 32'(`DPSS_DIAG1_PTR);
               end else begin
                  prdata_d = 32'h0;
               end
            end
            `DPSS_OFS_BAUD_ROOT >> 2: prdata_d = 32'(baud_root_q);
            `DPSS_OFS_IND_STAT  >> 2: prdata_d = 32'(ind_stat_q);
            `DPSS_OFS_IND_EN    >> 2: prdata_d = 32'(ind_en_q);
            `DPSS_OFS_STATUS    >> 2: prdata_d = {26'h0, diag_free_q, 1'b0, io_ok_q,
                                                  baud_search_q, online_q};
            `DPSS_OFS_CFG_ID    >> 2: prdata_d = 32'(id_cnt_q);
            `DPSS_OFS_CFG_CALC  >> 2: prdata_d = calc_ok ? {15'h0, 1'b1, acc_out_q[7:0], acc_in_q[7:0]}
                                                         : 32'h0;
            default:                  pslverr_d = 1'b1;
         endcase
      end
   end

   // Registers
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_q       <= dpss_pkg::ST_OFFLINE;
         online_q      <= 1'b0;
         baud_search_q <= 1'b0;
         cfg_len_q     <= 8'h00;
         in_len_q      <= 8'h00;
         out_len_q     <= 8'h00;
         io_ok_q       <= 1'b0;
         baud_root_q   <= `DPSS_BAUD_ROOT_RST;
         ind_stat_q    <= 16'h0000;
         ind_en_q      <= `DPSS_IND_EN_RST;
         irq_q         <= 1'b0;
         diag_free_q   <= 2'b11;
         acc_in_q      <= 9'h000;
         acc_out_q     <= 9'h000;
         id_cnt_q      <= 8'h00;
         pready_q      <= 1'b0;
         prdata_q      <= 32'h0;
         pslverr_q     <= 1'b0;
      end else begin
         state_q       <= state_d;
         online_q      <= online_d;
         baud_search_q <= search_d;
         cfg_len_q     <= cfg_len_d;
         in_len_q      <= in_len_d;
         out_len_q     <= out_len_d;
         io_ok_q       <= io_ok_d;
         baud_root_q   <= baud_root_d;
         ind_stat_q    <= ind_stat_d;
         ind_en_q      <= ind_en_d;
         irq_q         <= irq_d;
         diag_free_q   <= diag_free_d;
         acc_in_q      <= acc_in_d;
         acc_out_q     <= acc_out_d;
         id_cnt_q      <= id_cnt_d;
         pready_q      <= pready_d;
         prdata_q      <= prdata_d;
         pslverr_q     <= pslverr_d;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   AST_CFG_PTR_READ: assert property (
      rd_done && hit(paddr, `DPSS_OFS_CFG_PTR) |-> prdata_q == 32'(`DPSS_CFG_BUF_PTR))
      else $error("Config pointer read wrong");

   AST_ID_INPUT_EIGHT: assert property (
      wr_done && hit(paddr, `DPSS_OFS_CFG_ID) && pwdata[7:0] == 8'h17 && acc_in_q < 9'h0F0
      |=> acc_in_q == $past(acc_in_q) + 9'h008 && acc_out_q == $past(acc_out_q))
      else $error("Input identifier decoded wrong");

   AST_ID_OUTPUT_EIGHT: assert property (
      wr_done && hit(paddr, `DPSS_OFS_CFG_ID) && pwdata[7:0] == 8'h27 && acc_out_q < 9'h0F0
      |=> acc_out_q == $past(acc_out_q) + 9'h008 && acc_in_q == $past(acc_in_q))
      else $error("Output identifier decoded wrong");

   AST_IO_MEM_CHECK: assert property (
      wr_done && hit(paddr, `DPSS_OFS_IO_LEN)
      |=> io_ok_q == ((10'(in_len_q) + 10'(out_len_q)) <= 10'(IO_MEM_BYTES)))
      else $error("Memory check result wrong");

   AST_DIAG_NULL: assert property (
      psel && penable && !pready_q && !pwrite && hit(paddr, `DPSS_OFS_DIAG_PTR) && diag_free_q == 2'b00
      |=> pready_q && prdata_q == 32'h0)
      else $error("Diagnostics pointer not null with no free buffer");

   AST_GO_ONLINE: assert property (
      wr_done && hit(paddr, `DPSS_OFS_CTRL) && pwdata[`DPSS_CTRL_GO] && state_q == dpss_pkg::ST_OFFLINE
      |=> ##1 online_q && baud_search_q)
      else $error("Start command did not bring slave online");

   AST_IRQ_ENABLED: assert property (
      |(ind_stat_q & ind_en_q) |-> irq_q)
      else $error("Enabled event without indication");

   AST_IRQ_MASKED: assert property (
      !(|(ind_stat_q & ind_en_q)) |-> !irq_q)
      else $error("Indication raised by disabled event");

   AST_REASON_FIELD: assert property (
      psel && penable && !pready_q && !pwrite && hit(paddr, `DPSS_OFS_IND_STAT)
      |=> prdata_q[31:16] == 16'h0 && prdata_q[15:0] == $past(ind_stat_q))
      else $error("Reason field read wrong");

   AST_BAUD_DETECT: assert property (
      state_q == dpss_pkg::ST_BAUD_SEARCH && link_in.baud_found
      |=> ind_stat_q[`DPSS_IND_BAUD_DET] && state_q == dpss_pkg::ST_ONLINE ##1 !baud_search_q)
      else $error("Baud detect not indicated");

   AST_WD_ROOT: assert property (
      state_q == dpss_pkg::ST_ONLINE && mon_expire |=> state_q == dpss_pkg::ST_BAUD_SEARCH)
      else $error("Monitor expiry did not restart baud search");

   COV_GO_ONLINE:  cover property (state_q == dpss_pkg::ST_OFFLINE ##1 state_q == dpss_pkg::ST_BAUD_SEARCH);
   COV_BAUD_FOUND: cover property (state_q == dpss_pkg::ST_BAUD_SEARCH ##1 state_q == dpss_pkg::ST_ONLINE);
   COV_DIAG_EMPTY: cover property (rd_done && hit(paddr, `DPSS_OFS_DIAG_PTR) && prdata_q == 32'h0);

endmodule : dpss_setup
`default_nettype wire

// ---- rtl/dpss_defs.svh ----
// Purpose: Offsets, field positions, reset values and timing counts of the slave start-up block
// Assumes: Included by bare name from the design modules and the bench
// Notes:   Definitions only
`ifndef DPSS_DEFS_SVH
`define DPSS_DEFS_SVH

// Register byte offsets
`define DPSS_OFS_CTRL       8'h00
`define DPSS_OFS_CFG_PTR    8'h04
`define DPSS_OFS_CFG_LEN    8'h08
`define DPSS_OFS_IO_LEN     8'h0C
`define DPSS_OFS_DIN_PTR    8'h10
`define DPSS_OFS_DIAG_PTR   8'h14
`define DPSS_OFS_BAUD_ROOT  8'h18
`define DPSS_OFS_IND_STAT   8'h1C
`define DPSS_OFS_IND_EN     8'h20
`define DPSS_OFS_STATUS     8'h24
`define DPSS_OFS_CFG_ID     8'h28
`define DPSS_OFS_CFG_CALC   8'h2C

// Control bits
`define DPSS_CTRL_GO        0
`define DPSS_CTRL_ID_CLR    1

// Buffer pointers into controller RAM
`define DPSS_CFG_BUF_PTR    16'h0040
`define DPSS_DIN_BUF_PTR    16'h0100
`define DPSS_DIAG0_PTR      16'h0200
`define DPSS_DIAG1_PTR      16'h0240

// Indication bit positions
`define DPSS_IND_BAUD_DET   2

// Reset values
`define DPSS_BAUD_ROOT_RST  8'hFF
`define DPSS_IND_EN_RST     16'h0000

// Identifier byte fields
`define DPSS_ID_LEN_MSB     3
`define DPSS_ID_IN          4
`define DPSS_ID_OUT         5
`define DPSS_ID_WORD        6

// Timing and I/O memory size
`define DPSS_CLK_MHZ        250
`define DPSS_TICK_MS        10
`define DPSS_IO_MEM_BYTES   488

`endif

// ---- rtl/dpss_pkg.sv ----
// Purpose: Types shared by the slave start-up block
// Assumes: Nothing beyond the defs header
// Notes:   Types only
`default_nettype none
package dpss_pkg;

   // Link state of the slave
   typedef enum logic [1:0] {
      ST_OFFLINE     = 2'b00,
      ST_BAUD_SEARCH = 2'b01,
      ST_ONLINE      = 2'b10
   } dpss_state_t;

   // Events and levels from the fieldbus engine
   typedef struct packed {
      logic        msg_valid;
      logic        baud_found;
      logic        wd_en;
      logic [7:0]  wd_value;
      logic        diag_returned;
      logic [15:0] events;
   } dpss_link_t;

endpackage : dpss_pkg
`default_nettype wire

// ---- rtl/dpss_baud_mon.sv ----
// Purpose: Baud monitoring timer, expires after root x root time-base ticks
// Assumes: Restart pulses on each valid message
// Notes:   Tick length is a parameter so simulation can shorten it
`timescale 1ns/1ps
`default_nettype none
`include "dpss_defs.svh"

module dpss_baud_mon #(
   parameter int unsigned TICK_CYCLES = `DPSS_TICK_MS * `DPSS_CLK_MHZ * 1000
) (
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       rst,
   // Control
   input  wire logic       run,
   input  wire logic       restart,
   input  wire logic [7:0] root,
   // Result
   output logic            expire_q
);

   logic [31:0] pre_q,   pre_d;
   logic [15:0] ticks_q, ticks_d;
   logic        expire_d;
   logic [15:0] limit;

   // Squared root value gives the tick limit
   assign limit = 16'(root) * 16'(root);

   // Prescaler and tick counter
   always_comb begin
      pre_d    = pre_q;
      ticks_d  = ticks_q;
      expire_d = 1'b0;
      if (!run || restart) begin
         pre_d   = 32'h0;
         ticks_d = 16'h0;
      end else if (pre_q == 32'(TICK_CYCLES - 1)) begin
         pre_d = 32'h0;
         if (ticks_q + 16'h1 >= limit) begin
            expire_d = 1'b1;
            ticks_d  = 16'h0;
         end else begin
            ticks_d = ticks_q + 16'h1;
         end
      end else begin
         pre_d = pre_q + 32'h1;
      end
   end

   // Registers
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pre_q    <= 32'h0;
         ticks_q  <= 16'h0;
         expire_q <= 1'b0;
      end else begin
         pre_q    <= pre_d;
         ticks_q  <= ticks_d;
         expire_q <= expire_d;
      end
   end

   AST_EXPIRE_NEEDS_LIMIT: assert property (@(posedge clock) disable iff (rst)
      expire_q |-> $past(run) && !$past(restart) && ($past(ticks_q) + 16'h1 >= $past(limit)))
      else $error("Baud monitor expired before its limit");

endmodule : dpss_baud_mon
`default_nettype wire

// ---- testbench/dpss_master_model.sv ----
// Purpose: Behavioural fieldbus master seen by the slave start-up block
// Assumes: Bench calls the tasks; all changes follow a rising edge
// Notes:   Pulses last exactly one cycle, watchdog fields are levels
`timescale 1ns/1ps
`default_nettype none

module dpss_master_model (
   // Clock
   input  wire logic                 clock,
   // Link towards the slave
   output var  dpss_pkg::dpss_link_t link_in
);
   initial link_in = '0;

   // One-cycle pulse of frame, baud, diag return or events
   task automatic pulse(input logic [2:0] which, input logic [15:0] ev);
      @(posedge clock);
      link_in.msg_valid     <= which[0];
      link_in.baud_found    <= which[1];
      link_in.diag_returned <= which[2];
      link_in.events        <= ev;
      @(posedge clock);
      link_in.msg_valid     <= 1'b0;
      link_in.baud_found    <= 1'b0;
      link_in.diag_returned <= 1'b0;
      link_in.events        <= 16'h0000;
   endtask : pulse

   // Master enables its own watchdog value
   task automatic watchdog(input logic en, input logic [7:0] val);
      @(posedge clock);
      link_in.wd_en    <= en;
      link_in.wd_value <= val;
   endtask : watchdog

   // Frames every third cycle keep the link alive
   task automatic frames(input int n);
      repeat (n) begin
         pulse(3'b001, 16'h0000);
         @(posedge clock);
      end
   endtask : frames
endmodule : dpss_master_model
`default_nettype wire

// ---- testbench/dpss_setup_tb.sv ----
// Purpose: Self-checking bench of the slave start-up block
// Assumes: Time-base tick shortened to 4 cycles
// Notes:   APB master waits for pready_q, no fixed latency
`timescale 1ns/1ps
`default_nettype none
`include "dpss_defs.svh"

module dpss_setup_tb;
   localparam int TICK = 4;
   logic                 clock = 1'b0;
   logic                 rst = 1'b1;
   logic                 psel = 1'b0;
   logic                 penable = 1'b0;
   logic                 pwrite = 1'b0;
   logic [7:0]           paddr = 8'h00;
   logic [31:0]          pwdata = 32'h00000000;
   logic                 pready_q;
   logic [31:0]          prdata_q;
   logic                 pslverr_q;
   dpss_pkg::dpss_link_t link_in;
   logic                 online_q;
   logic                 baud_search_q;
   logic                 irq_q;
   int                   err_total = 0;
   int                   cmp_count = 0;

   // Device under test and far-side master
   dpss_setup #(.TICK_CYCLES(TICK), .IO_MEM_BYTES(488)) DUT (
      .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready_q(pready_q), .prdata_q(prdata_q),
      .pslverr_q(pslverr_q), .link_in(link_in), .online_q(online_q),
      .baud_search_q(baud_search_q), .irq_q(irq_q));
   dpss_master_model u_master (.clock(clock), .link_in(link_in));

   // Clock of 4 ns
   always #2 clock = ~clock;

   // Compare and count
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         $display("ERROR %s expected %h seen %h", what, exp, got);
         err_total++;
      end
   endtask : chk

   // One APB transfer, held until pready_q is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      @(posedge clock);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
         n++;
      end while ((pready_q !== 1'b1) && (n < 40));
      if (n >= 40) chk("pready_q", 32'h1, 32'h0);
      rd = prdata_q;
      err = pslverr_q;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic        e;
      apb(1'b1, a, d, rd, e);
   endtask : wr

   task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] rd;
      logic        e;
      apb(1'b0, a, 32'h00000000, rd, e);
      chk(what, exp, rd);
   endtask : rdchk

   // Reset values and fixed buffer pointers
   task automatic t_reset();
      chk("online_q", 32'h0, {31'h0, online_q});
      rdchk("baud_root", `DPSS_OFS_BAUD_ROOT, 32'h000000FF);
      rdchk("ind_en", `DPSS_OFS_IND_EN, 32'h00000000);
      rdchk("ind_stat", `DPSS_OFS_IND_STAT, 32'h00000000);
      rdchk("cfg_ptr", `DPSS_OFS_CFG_PTR, 32'h00000040);
      rdchk("din_ptr", `DPSS_OFS_DIN_PTR, 32'h00000100);
   endtask : t_reset

   // Identifiers 17 and 27 hex, then zero configuration length
   task automatic t_config();
      wr(`DPSS_OFS_CTRL, 32'h00000002);
      wr(`DPSS_OFS_CFG_ID, 32'h00000017);
      wr(`DPSS_OFS_CFG_ID, 32'h00000027);
      wr(`DPSS_OFS_CFG_LEN, 32'h00000002);
      rdchk("cfg_calc", `DPSS_OFS_CFG_CALC, 32'h00010808);
      wr(`DPSS_OFS_CFG_LEN, 32'h00000000);
      rdchk("cfg_calc_zero", `DPSS_OFS_CFG_CALC, 32'h00000000);
      wr(`DPSS_OFS_CFG_ID, 32'h00000017);
      rdchk("cfg_id_count", `DPSS_OFS_CFG_ID, 32'h00000003);
      wr(`DPSS_OFS_CFG_LEN, 32'h00000002);
      rdchk("cfg_calc_count", `DPSS_OFS_CFG_CALC, 32'h00000000);
      wr(`DPSS_OFS_CFG_LEN, 32'h00000003);
      rdchk("cfg_len", `DPSS_OFS_CFG_LEN, 32'h00000003);
      rdchk("cfg_calc_acc", `DPSS_OFS_CFG_CALC, 32'h00010810);
      wr(`DPSS_OFS_CFG_ID, 32'h00000050);
      wr(`DPSS_OFS_CFG_LEN, 32'h00000004);
      rdchk("cfg_calc_word", `DPSS_OFS_CFG_CALC, 32'h00010812);
   endtask : t_config

   // Memory check at the 488-byte boundary
   task automatic t_io_len();
      wr(`DPSS_OFS_IO_LEN, 32'h00000808);
      rdchk("io_len_small", `DPSS_OFS_IO_LEN, 32'h00010808);
      wr(`DPSS_OFS_IO_LEN, 32'h0000F5F4);
      rdchk("io_len_over", `DPSS_OFS_IO_LEN, 32'h0000F5F4);
      wr(`DPSS_OFS_IO_LEN, 32'h0000F4F4);
      rdchk("io_len_edge", `DPSS_OFS_IO_LEN, 32'h0001F4F4);
   endtask : t_io_len

   // Two diag buffers, then none, then one returned
   task automatic t_diag();
      logic [31:0] rd;
      logic        e;
      rdchk("diag_a", `DPSS_OFS_DIAG_PTR, 32'h00000200);
      rdchk("diag_b", `DPSS_OFS_DIAG_PTR, 32'h00000240);
      rdchk("diag_none", `DPSS_OFS_DIAG_PTR, 32'h00000000);
      u_master.pulse(3'b100, 16'h0000);
      apb(1'b0, `DPSS_OFS_DIAG_PTR, 32'h00000000, rd, e);
      chk("diag_again", 32'h1, {31'h0, (rd === 32'h00000200) || (rd === 32'h00000240)});
   endtask : t_diag

   // Unmapped word and read-only pointer
   task automatic t_refuse();
      logic [31:0] rd;
      logic        e;
      apb(1'b0, 8'h30, 32'h00000000, rd, e);
      chk("unmapped_err", 32'h1, {31'h0, e});
      chk("unmapped_data", 32'h0, rd);
      wr(`DPSS_OFS_CFG_PTR, 32'h00001234);
      rdchk("cfg_ptr_ro", `DPSS_OFS_CFG_PTR, 32'h00000040);
   endtask : t_refuse

   // Disabled event is pollable but silent, then unmasked
   task automatic t_mask();
      u_master.pulse(3'b000, 16'h0020);
      repeat (2) @(posedge clock);
      chk("irq_masked", 32'h0, {31'h0, irq_q});
      rdchk("stat_poll", `DPSS_OFS_IND_STAT, 32'h00000020);
      wr(`DPSS_OFS_IND_EN, 32'h00000020);
      repeat (2) @(posedge clock);
      chk("irq_unmasked", 32'h1, {31'h0, irq_q});
      wr(`DPSS_OFS_IND_STAT, 32'h00000020);
      repeat (2) @(posedge clock);
      chk("irq_cleared", 32'h0, {31'h0, irq_q});
   endtask : t_mask

   // Start, baud found, indication bit 2
   task automatic t_start();
      wr(`DPSS_OFS_IND_EN, 32'h00000004);
      wr(`DPSS_OFS_CTRL, 32'h00000001);
      repeat (3) @(posedge clock);
      chk("online_go", 32'h1, {31'h0, online_q});
      chk("search_go", 32'h1, {31'h0, baud_search_q});
      rdchk("status_go", `DPSS_OFS_STATUS, 32'h00000007);
      u_master.pulse(3'b010, 16'h0000);
      repeat (2) @(posedge clock);
      chk("search_left", 32'h0, {31'h0, baud_search_q});
      chk("irq_baud", 32'h1, {31'h0, irq_q});
      rdchk("stat_baud", `DPSS_OFS_IND_STAT, 32'h00000004);
      wr(`DPSS_OFS_IND_STAT, 32'h00000004);
   endtask : t_start

   // Silence for root x root ticks returns to search
   task automatic t_silence(input string what, input int quiet, input int limit);
      int n;
      u_master.frames(10);
      chk({what, "_alive"}, 32'h0, {31'h0, baud_search_q});
      repeat (quiet) @(posedge clock);
      chk({what, "_early"}, 32'h0, {31'h0, baud_search_q});
      n = 0;
      while ((baud_search_q !== 1'b1) && (n < limit)) begin
         @(posedge clock);
         n++;
      end
      chk({what, "_expired"}, 32'h1, {31'h0, baud_search_q});
      u_master.pulse(3'b010, 16'h0000);
      repeat (2) @(posedge clock);
   endtask : t_silence

   task automatic t_monitor();
      wr(`DPSS_OFS_BAUD_ROOT, 32'h00000002);
      t_silence("local", 8, 24);
      u_master.watchdog(1'b1, 8'h03);
      t_silence("master", 22, 40);
      u_master.watchdog(1'b0, 8'h00);
   endtask : t_monitor

   // Counts and verdict
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if ((err_total == 0) && (cmp_count > 0))
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : test_done

   // Hang guard
   initial begin
      repeat (20000) @(posedge clock);
      err_total++;
      test_done();
   end

   // Main sequence
   initial begin
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      t_reset();
      t_config();
      t_io_len();
      t_diag();
      t_refuse();
      t_mask();
      t_start();
      t_monitor();
      test_done();
   end
endmodule : dpss_setup_tb
`default_nettype wire
